// >>> logic/dfpc_pkg.sv
// Package of offsets, field positions and reset values for the DMA FIFO port block
package dfpc_pkg;
    // Register indices (printed offsets are not all multiples of four: byte address is index * 4)
    localparam logic [7:0]  CH0_COUNT_IDX   = 8'h4e;
    localparam logic [7:0]  CH1_COUNT_IDX   = 8'h56;
    localparam logic [7:0]  CH0_CONTROL_IDX = 8'h4a;
    localparam logic [7:0]  CH1_CONTROL_IDX = 8'h52;
    localparam logic [7:0]  CH0_PORT_IDX    = 8'h60;
    localparam logic [7:0]  CH1_PORT_IDX    = 8'h62;
    localparam logic [7:0]  CH0_EPCFG_IDX   = 8'h64;
    localparam logic [7:0]  CH1_EPCFG_IDX   = 8'h66;
    localparam logic [7:0]  CH0_RXPKT_IDX   = 8'h68;
    localparam logic [7:0]  CH1_RXPKT_IDX   = 8'h6a;
    // Control register fields
    localparam int          CTL_CLEAR_BIT   = 15;
    localparam int          CTL_COUNT_EN    = 14;
    localparam int          CTL_COMMIT_BIT  = 13;
    localparam int          CTL_NOTREADY    = 11;
    localparam int          CTL_LEN_MSB     = 10;
    // Endpoint configuration fields
    localparam int          CFG_DIR_BIT     = 0;
    localparam int          CFG_CONT_BIT    = 1;
    localparam int          CFG_TYPE_LSB    = 2;
    localparam int          CFG_OCTET_BIT   = 4;
    localparam int          CFG_DMA_ON_BIT  = 5;
    localparam logic [1:0]  TYPE_BULK       = 2'h1;
    // Reset values, FIFO width and depth
    localparam logic [15:0] COUNT_RESET     = 16'h0000;
    localparam logic [5:0]  EPCFG_RESET     = 6'h00;
    localparam int          FIFO_WIDTH      = 17;
    localparam int          FIFO_DEPTH      = 16;
endpackage : dfpc_pkg

// >>> logic/dfpc_fifo.sv
// Synchronous valid/ready FIFO with parameterised width and depth
`timescale 1ns/10ps
`default_nettype none
module dfpc_fifo #(
    parameter int WIDTH = 17,
    parameter int DEPTH = 16
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             flush,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data,
    output logic      [$clog2(DEPTH):0] level
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic             push;
    logic             pop;

    // Full and empty follow straight from the fill level
    assign in_ready  = (level != (AW+1)'(DEPTH));
    assign out_valid = (level != '0);
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;
    assign out_data  = mem[rd_ptr];

    // Storage has no reset; contents are meaningless while empty
    always_ff @(posedge pclk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    // Pointers and level
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            level  <= '0;
        end else if (flush) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            level  <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
            end
            level <= level + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : dfpc_fifo
`default_nettype wire

// >>> logic/dfpc_port.sv
// Two DMA-side FIFO data ports with packet transaction counters, APB slave
`timescale 1ns/10ps
`default_nettype none
// Function
// - OUT endpoint: port read returns received data
// - IN endpoint: port write deposits transmit data
// - 8-bit mode ignores upper data byte
// - 16-bit mode tracks single-byte writes
// - Commit or transfer end sends odd byte
// - Counter only for bulk continuous OUT
// - Count match also completes reception
// - Count one per received packet
// - Enabled: read current, write compare
// - Disabled: reads and writes reach compare
// - Clear bit clears count, reads zero
// - Not-ready blocks port, hides commit, length
// - Bit 14 enables counting function
module dfpc_port #(
    parameter int FIFO_DEPTH = dfpc_pkg::FIFO_DEPTH
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [9:0]  paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        bus_width_pin,
    input  wire logic [1:0]  transfer_end_pin,
    input  wire logic [1:0]  rx_valid,
    output logic      [1:0]  rx_ready,
    input  wire logic [15:0] rx_data0,
    input  wire logic [15:0] rx_data1,
    input  wire logic [1:0]  rx_odd,
    input  wire logic [1:0]  rx_packet_end,
    output logic      [1:0]  rx_complete,
    output logic      [1:0]  tx_valid,
    input  wire logic [1:0]  tx_ready,
    output logic      [15:0] tx_data0,
    output logic      [15:0] tx_data1,
    output logic      [1:0]  tx_odd,
    output logic      [1:0]  tx_commit
);
    // Fill level is one bit wider than the pointers so full and empty differ
    localparam int LW = $clog2(FIFO_DEPTH) + 1;

    // Address decode, byte address is index times four
    logic        setup;
    logic [1:0]  hit_cnt;
    logic [1:0]  hit_ctl;
    logic [1:0]  hit_port;
    logic [1:0]  hit_cfg;
    logic [1:0]  hit_rx;
    logic        mapped;
    logic        wr_en;
    logic        rd_en;
    // Per-channel state (fully separate per channel)
    logic [15:0] current   [2];
    logic [15:0] compare   [2];
    logic [15:0] rx_pkts   [2];
    logic [5:0]  epcfg     [2];
    logic [1:0]  count_en;
    logic [1:0]  commit;
    logic [1:0]  dir_flush;
    logic [1:0]  in_full;
    logic [1:0]  out_empty;
    logic [1:0]  eight_bit;
    logic [1:0]  counting;
    logic [1:0]  is_out;
    logic [16:0] fout      [2];
    logic [16:0] fin       [2];
    logic [1:0]  fin_valid;
    logic [1:0]  fout_valid;
    logic [1:0]  fout_ready;
    logic [1:0]  fin_ready;
    logic [LW-1:0] flevel  [2];
    logic [1:0]  rd_pop;
    logic [1:0]  wr_push;
    logic [31:0] next_prdata;

    assign setup  = psel & ~penable;
    assign wr_en  = setup & pwrite;
    assign rd_en  = setup & ~pwrite;
    assign mapped = |{hit_cnt, hit_ctl, hit_port, hit_cfg, hit_rx};

    for (genvar c = 0; c < 2; c++) begin : g_ch
        localparam logic [7:0] A_CNT = c ? dfpc_pkg::CH1_COUNT_IDX : dfpc_pkg::CH0_COUNT_IDX;
        localparam logic [7:0] A_CTL = c ? dfpc_pkg::CH1_CONTROL_IDX : dfpc_pkg::CH0_CONTROL_IDX;
        localparam logic [7:0] A_PRT = c ? dfpc_pkg::CH1_PORT_IDX : dfpc_pkg::CH0_PORT_IDX;
        localparam logic [7:0] A_CFG = c ? dfpc_pkg::CH1_EPCFG_IDX : dfpc_pkg::CH0_EPCFG_IDX;
        localparam logic [7:0] A_RX  = c ? dfpc_pkg::CH1_RXPKT_IDX : dfpc_pkg::CH0_RXPKT_IDX;
        logic        clear_hit;
        logic        match;
        logic        port_ok;
        logic [15:0] wdata;

        // Each channel decodes only its own addresses
        assign hit_cnt[c]  = (paddr == {A_CNT, 2'b00});
        assign hit_ctl[c]  = (paddr == {A_CTL, 2'b00});
        assign hit_port[c] = (paddr == {A_PRT, 2'b00});
        assign hit_cfg[c]  = (paddr == {A_CFG, 2'b00});
        assign hit_rx[c]   = (paddr == {A_RX, 2'b00});
        assign wdata       = pwdata[15:0];
        // A direction change empties the buffer so no stale word crosses over
        assign dir_flush[c] = wr_en & hit_cfg[c] & pstrb[0]
            & (wdata[dfpc_pkg::CFG_DIR_BIT] ^ epcfg[c][dfpc_pkg::CFG_DIR_BIT]);
        // 8-bit mode from the endpoint configuration bit or the pin
        assign eight_bit[c] = epcfg[c][dfpc_pkg::CFG_OCTET_BIT] | bus_width_pin;
        assign is_out[c]    = ~epcfg[c][dfpc_pkg::CFG_DIR_BIT];
        // Counter only for bulk continuous receive on an OUT endpoint
        assign counting[c] = count_en[c] & is_out[c]
            & epcfg[c][dfpc_pkg::CFG_CONT_BIT]
            & (epcfg[c][dfpc_pkg::CFG_TYPE_LSB +: 2] == dfpc_pkg::TYPE_BULK);
        assign match     = counting[c] & (current[c] == compare[c]) & (compare[c] != '0);
        assign clear_hit = wr_en & hit_ctl[c] & pstrb[1] & wdata[dfpc_pkg::CTL_CLEAR_BIT];
        // Port not ready: no data to read, or no room to write or a commit pending
        assign in_full[c]   = ~fin_ready[c] | commit[c];
        assign out_empty[c] = ~fout_valid[c];
        assign port_ok      = is_out[c] ? ~out_empty[c] : ~in_full[c];
        assign rd_pop[c]    = rd_en & hit_port[c] & is_out[c] & port_ok;
        assign wr_push[c]   = wr_en & hit_port[c] & ~is_out[c] & port_ok;
        assign fout_ready[c] = rd_pop[c];
        assign fin_valid[c]  = wr_push[c];
        // A write of the low byte alone in 16-bit mode marks an odd byte
        // Upper byte is zeroed in 8-bit mode so stale bus bits never reach the link
        assign fin[c] = {eight_bit[c] | (pstrb[1:0] == 2'b01),
                         eight_bit[c] ? 8'h00 : wdata[15:8], wdata[7:0]};

        // Endpoint configuration
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                epcfg[c] <= dfpc_pkg::EPCFG_RESET;
            end else if (wr_en & hit_cfg[c] & pstrb[0]) begin
                epcfg[c] <= wdata[5:0];
            end
        end

        // Count enable
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                count_en[c] <= 1'b0;
            end else if (wr_en & hit_ctl[c] & pstrb[1]) begin
                count_en[c] <= wdata[dfpc_pkg::CTL_COUNT_EN];
            end
        end

        // Compare value: half-word writes only, so a byte write cannot tear it
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                compare[c] <= dfpc_pkg::COUNT_RESET;
            end else if (wr_en & hit_cnt[c] & (&pstrb[1:0])) begin
                compare[c] <= wdata;
            end
        end

        // Current packet count: a packet that ends as clear lands counts as one
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                current[c] <= dfpc_pkg::COUNT_RESET;
                rx_pkts[c] <= dfpc_pkg::COUNT_RESET;
            end else begin
                if (clear_hit) begin
                    current[c] <= 16'(counting[c] & rx_packet_end[c]);
                end else if (counting[c] & rx_packet_end[c]) begin
                    current[c] <= current[c] + 16'h0001;
                end
                // Raw tally runs whatever the enable, for diagnostics
                if (rx_packet_end[c]) begin
                    rx_pkts[c] <= rx_pkts[c] + 16'h0001;
                end
            end
        end

        // Commit: software flag or end pin closes the buffer
        // A commit holds port writes off until the buffer has drained
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                commit[c] <= 1'b0;
            end else begin
                if (~is_out[c] & ((wr_en & hit_ctl[c] & pstrb[1]
                        & wdata[dfpc_pkg::CTL_COMMIT_BIT]) | transfer_end_pin[c])) begin
                    commit[c] <= 1'b1;
                end else if (commit[c] & ~fout_valid_in(c)) begin
                    commit[c] <= 1'b0;
                end
            end
        end

        // Receive side: ready is a flop, so it falls one word early to leave room
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                rx_complete[c] <= 1'b0;
                rx_ready[c]    <= 1'b0;
            end else begin
                rx_complete[c] <= match;
                rx_ready[c]    <= is_out[c] & (flevel[c] < LW'(FIFO_DEPTH - 1));
            end
        end

        // Transmit marks: the odd flag travels with its own word
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                tx_commit[c] <= 1'b0;
                tx_odd[c]    <= 1'b0;
            end else begin
                tx_commit[c] <= commit[c] & ~fout_valid_in(c);
                tx_odd[c]    <= fout[c][16];
            end
        end

        dfpc_fifo #(
            .WIDTH     (dfpc_pkg::FIFO_WIDTH),
            .DEPTH     (FIFO_DEPTH)
        ) u_fifo (
            .pclk      (pclk),
            .presetn   (presetn),
            .flush     (dir_flush[c]),
            .in_valid  (is_out[c] ? (rx_valid[c] & rx_ready[c]) : fin_valid[c]),
            .in_ready  (fin_ready[c]),
            .in_data   (is_out[c] ? {rx_odd[c], (c ? rx_data1 : rx_data0)} : fin[c]),
            .out_valid (fout_valid[c]),
            .out_ready (is_out[c] ? fout_ready[c] : (tx_ready[c] & tx_valid[c])),
            .out_data  (fout[c]),
            .level     (flevel[c])
        );
    end

    // True while the IN buffer still holds words for the link
    function automatic logic fout_valid_in(input int c);
        return ~is_out[c] & fout_valid[c];
    endfunction : fout_valid_in

    // Transmit stream toward the serial interface engine
    // Valid drops a cycle after each accepted word: half rate, but no skid buffer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_valid <= 2'b00;
            tx_data0 <= 16'h0000;
            tx_data1 <= 16'h0000;
        end else begin
            tx_valid <= {fout_valid_in(1) & ~(tx_valid[1] & tx_ready[1]),
                         fout_valid_in(0) & ~(tx_valid[0] & tx_ready[0])};
            tx_data0 <= fout[0][15:0];
            tx_data1 <= fout[1][15:0];
        end
    end

    // Read mux; reads of the count register depend on the enable
    always_comb begin
        next_prdata = 32'h0000_0000;
        for (int c = 0; c < 2; c++) begin
            if (hit_cnt[c]) begin
                next_prdata[15:0] = count_en[c] ? current[c] : compare[c];
            end
            // Not ready means empty for OUT, full or committed for IN
            if (hit_ctl[c]) begin
                next_prdata[dfpc_pkg::CTL_COUNT_EN] = count_en[c];
                next_prdata[dfpc_pkg::CTL_NOTREADY] = is_out[c] ? out_empty[c] : in_full[c];
                // Commit and length read zero while the port is not ready
                if (!(is_out[c] ? out_empty[c] : in_full[c])) begin
                    next_prdata[dfpc_pkg::CTL_COMMIT_BIT] = is_out[c] ? 1'b1 : commit[c];
                    next_prdata[dfpc_pkg::CTL_LEN_MSB:0] =
                        is_out[c] ? 11'({flevel[c], 1'b0}) : 11'h000;
                end
            end
            if (hit_port[c] & rd_pop[c]) begin
                next_prdata[15:0] = eight_bit[c] ? {8'h00, fout[c][7:0]} : fout[c][15:0];
            end
            if (hit_cfg[c]) begin
                next_prdata[5:0] = epcfg[c];
            end
            if (hit_rx[c]) begin
                next_prdata[15:0] = rx_pkts[c];
            end
        end
    end

    // APB answer: one wait-free access phase; data captured at setup
    // Writes and pops act on the setup edge; the access phase only answers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= setup;
            pslverr <= setup & ~mapped;
            if (rd_en) begin
                prdata <= next_prdata;
            end
        end
    end
endmodule : dfpc_port
`default_nettype wire

// >>> verif/dfpc_port_checker.sv
// Concurrent checks on the bus and stream ports of the DMA FIFO port block
`timescale 1ns/10ps
`default_nettype none
module dfpc_port_checker (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [9:0]  paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [1:0]  rx_packet_end,
    input wire logic [1:0]  rx_complete,
    input wire logic [1:0]  tx_valid,
    input wire logic [1:0]  tx_ready,
    input wire logic [15:0] tx_data0,
    input wire logic [15:0] tx_data1
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // A request is taken on its setup cycle
    sequence s_setup;
        psel && !penable;
    endsequence
    // Read of the channel 0 control word
    sequence s_ctl_read;
        psel && !penable && !pwrite && paddr == 10'h128;
    endsequence
    chk_answer_next: assert property (s_setup |=> pready)
        else $error("no answer after setup");
    chk_ready_pulse: assert property (pready |=> !pready)
        else $error("pready held two cycles");
    chk_err_with_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    chk_unmapped_err: assert property (s_setup ##0 paddr == 10'h3fc |=> pslverr)
        else $error("unmapped address without pslverr");
    chk_clear_reads_zero: assert property (s_ctl_read |=> !prdata[15])
        else $error("clear bit reads one");
    // Quiet bus and no packet leaves a count match in place
    chk_complete_holds: assert property (rx_complete[0] && !psel && !$past(psel)
        && !rx_packet_end[0] && !$past(rx_packet_end[0]) |=> rx_complete[0])
        else $error("count match dropped without cause");
    chk_complete_cause: assert property ($rose(rx_complete[0])
        |-> $past(rx_packet_end[0], 1) || $past(rx_packet_end[0], 2) || $past(psel))
        else $error("count match with no packet");
    chk_tx_hold0: assert property (tx_valid[0] && !tx_ready[0]
        |=> tx_valid[0] && $stable(tx_data0))
        else $error("channel 0 transmit word not held");
    chk_tx_hold1: assert property (tx_valid[1] && !tx_ready[1]
        |=> tx_valid[1] && $stable(tx_data1))
        else $error("channel 1 transmit word not held");
endmodule : dfpc_port_checker
`default_nettype wire

// >>> verif/dfpc_apb_host.sv
// Bus master model standing for the DMA controller or host processor
`timescale 1ns/10ps
`default_nettype none
module dfpc_apb_host (
    input  wire logic        pclk,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic      [9:0]  paddr,
    output logic      [31:0] pwdata,
    output logic      [3:0]  pstrb,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    initial begin
        {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    end
    // One transfer; idles a cycle after so a new setup never lands on the release
    // Callers enable DMA on the channel, so the not-ready poll is skipped
    task automatic xfer(input logic wr, input logic [9:0] a, input logic [31:0] d,
                        input logic [3:0] s, output logic [31:0] q, output logic e);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        pstrb   <= s;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : xfer
endmodule : dfpc_apb_host
`default_nettype wire

// >>> verif/test_dma_fifo_port_with_packet_counter.sv
// Self-checking bench for the DMA FIFO port block with packet counters
`timescale 1ns/10ps
`default_nettype none
module test_dma_fifo_port_with_packet_counter;
    localparam logic [9:0] CNT0 = {dfpc_pkg::CH0_COUNT_IDX, 2'b00};
    localparam logic [9:0] CNT1 = {dfpc_pkg::CH1_COUNT_IDX, 2'b00};
    localparam logic [9:0] CTL0 = {dfpc_pkg::CH0_CONTROL_IDX, 2'b00};
    localparam logic [9:0] PRT0 = {dfpc_pkg::CH0_PORT_IDX, 2'b00};
    localparam logic [9:0] PRT1 = {dfpc_pkg::CH1_PORT_IDX, 2'b00};
    localparam logic [9:0] CFG0 = {dfpc_pkg::CH0_EPCFG_IDX, 2'b00};
    localparam logic [9:0] CFG1 = {dfpc_pkg::CH1_EPCFG_IDX, 2'b00};
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, bus_width_pin;
    logic [9:0]  paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0]  pstrb;
    logic [1:0]  transfer_end_pin, rx_valid, rx_ready, rx_odd, rx_packet_end, rx_complete;
    logic [1:0]  tx_valid, tx_ready, tx_odd, tx_commit, seen_c;
    logic [15:0] rx_data0, rx_data1, tx_data0, tx_data1;
    logic [17:0] q0[$], q1[$];
    int          bad_count, compares, cycles;
    dfpc_port u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .bus_width_pin(bus_width_pin),
        .transfer_end_pin(transfer_end_pin), .rx_valid(rx_valid), .rx_ready(rx_ready),
        .rx_data0(rx_data0), .rx_data1(rx_data1), .rx_odd(rx_odd),
        .rx_packet_end(rx_packet_end), .rx_complete(rx_complete), .tx_valid(tx_valid),
        .tx_ready(tx_ready), .tx_data0(tx_data0), .tx_data1(tx_data1), .tx_odd(tx_odd),
        .tx_commit(tx_commit));
    dfpc_apb_host u_host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    // Transmit monitor: every accepted word with its odd and commit marks
    always @(posedge pclk) begin
        if (tx_valid[0] === 1'b1 && tx_ready[0] === 1'b1) q0.push_back({tx_commit[0], tx_odd[0], tx_data0});
        if (tx_valid[1] === 1'b1 && tx_ready[1] === 1'b1) q1.push_back({tx_commit[1], tx_odd[1], tx_data1});
        seen_c <= seen_c | tx_commit;
    end
    // Hang guard: the whole run needs well under two thousand cycles
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            results();
        end
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic wr(input logic [9:0] a, input logic [31:0] d, input logic [3:0] s);
        logic [31:0] q;
        logic        e;
        u_host.xfer(1'b1, a, d, s, q, e);
    endtask : wr
    task automatic rd(input logic [9:0] a, output logic [31:0] q);
        logic e;
        u_host.xfer(1'b0, a, 32'h0, 4'h0, q, e);
    endtask : rd
    task automatic pkt;
        rx_packet_end[0] <= 1'b1;
        @(posedge pclk);
        rx_packet_end[0] <= 1'b0;
        @(posedge pclk);
    endtask : pkt
    task automatic t_regs;
        logic [31:0] q;
        logic        e;
        rd(CNT0, q);
        check("count0 reset", 32'(q[15:0]), 32'h0);
        u_host.xfer(1'b0, 10'h3fc, 32'h0, 4'h0, q, e);
        check("unmapped error", 32'(e), 32'h1);
        wr(CNT0, 32'h1234, 4'hf);
        rd(CNT0, q);
        check("compare0", 32'(q[15:0]), 32'h1234);
        rd(CNT1, q);
        check("count1 untouched", 32'(q[15:0]), 32'h0);
        $display("test registers done");
    endtask : t_regs
    task automatic t_count;
        logic [31:0] q;
        wr(CFG0, 32'h26, 4'hf);
        wr(CTL0, 32'hc000, 4'hf);
        wr(CNT0, 32'h3, 4'h3);
        for (int i = 1; i <= 3; i++) begin
            pkt();
            rd(CNT0, q);
            check("current count", 32'(q[15:0]), 32'(i));
            check("count match", 32'(rx_complete[0]), 32'(i == 3));
        end
        wr(CTL0, 32'hc000, 4'hf);
        rd(CNT0, q);
        check("cleared count", 32'(q[15:0]), 32'h0);
        check("match after clear", 32'(rx_complete[0]), 32'h0);
        rd(CTL0, q);
        check("clear bit read", 32'(q[15]), 32'h0);
        wr(CTL0, 32'h0, 4'hf);
        rd(CNT0, q);
        check("compare when off", 32'(q[15:0]), 32'h3);
        wr(CFG0, 32'h22, 4'hf);
        wr(CTL0, 32'hc000, 4'hf);
        wr(CNT0, 32'h1, 4'h3);
        pkt();
        rd(CNT0, q);
        check("no match off bulk", 32'(rx_complete[0]), 32'h0);
        $display("test counter done");
    endtask : t_count
    task automatic t_out;
        logic [31:0] q;
        int          n;
        n = 0;
        wr(CFG0, 32'h20, 4'hf);
        rx_valid[0] <= 1'b1;
        rx_data0    <= 16'ha000;
        for (int k = 0; k < 30; k++) begin
            @(posedge pclk);
            if (rx_ready[0] === 1'b1) begin
                n++;
                rx_data0 <= 16'ha000 + 16'(n);
            end
        end
        rx_valid[0] <= 1'b0;
        check("fill refused near full", 32'(n == 15 || n == 16), 32'h1);
        rd(CTL0, q);
        check("length when full", 32'(q[13:0]), 32'h2000 + 32'(2 * n));
        for (int i = 0; i < n; i++) begin
            rd(PRT0, q);
            check("port0 read", 32'(q[15:0]), 32'ha000 + 32'(i));
        end
        check("room after drain", 32'(rx_ready[0]), 32'h1);
        rd(CTL0, q);
        check("not ready when empty", 32'(q[13:0]), 32'h0800);
        $display("test receive done");
    endtask : t_out
    task automatic t_in;
        int k;
        k = 0;
        wr(CFG0, 32'h21, 4'hf);
        wr(PRT0, 32'h5aa5, 4'h3);
        wr(PRT0, 32'h0077, 4'h1);
        wr(CTL0, 32'h2000, 4'hf);
        tx_ready[0] <= 1'b1;
        while (k < 60 && !(q0.size() == 2 && seen_c[0])) begin
            @(posedge pclk);
            k++;
        end
        check("tx0 words", 32'(q0.size()), 32'h2);
        check("tx0 full word", 32'(q0[0][16:0]), 32'h5aa5);
        check("tx0 odd byte", 32'({q0[1][16], q0[1][7:0]}), 32'h177);
        check("tx0 committed", 32'(seen_c[0]), 32'h1);
        bus_width_pin <= 1'b1;
        wr(CFG1, 32'h21, 4'hf);
        wr(PRT1, 32'hab34, 4'h3);
        tx_ready[1]         <= 1'b1;
        transfer_end_pin[1] <= 1'b1;
        @(posedge pclk);
        transfer_end_pin[1] <= 1'b0;
        for (k = 0; k < 60 && !(q1.size() == 1 && seen_c[1]); k++) @(posedge pclk);
        check("tx1 low byte", 32'(q1[0][15:0]), 32'h34);
        check("tx1 committed", 32'(seen_c[1]), 32'h1);
        check("tx0 untouched", 32'(q0.size()), 32'h2);
        $display("test transmit done");
    endtask : t_in
    task automatic results;
        $display("comparisons %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : results
    initial begin
        {presetn, bus_width_pin, transfer_end_pin, rx_valid, rx_odd} = '0;
        {rx_packet_end, tx_ready, rx_data0, rx_data1, seen_c} = '0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_regs();
        t_count();
        t_out();
        t_in();
        results();
    end
endmodule : test_dma_fifo_port_with_packet_counter
bind dfpc_port dfpc_port_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx_packet_end(rx_packet_end), .rx_complete(rx_complete),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data0(tx_data0), .tx_data1(tx_data1));
`default_nettype wire
